/* core/opm_ctrl.sv */
// operating mode power controller with wishbone register slave
`timescale 1ns/1ps
`include "opm_consts.svh"

module opm_ctrl #(
  parameter int NPERIPH = `OPM_NPERIPH,
  parameter int NPINS = `OPM_NPINS,
  parameter logic [15:0] BOOT_CYC = `OPM_BOOT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // asynchronous wakeup sources
  input wire logic rtc_wake_i,
  input wire logic ext_wake_i,
  input wire logic reset_pin_i,
  // clock tree, supply and boot
  output opm_pkg::opm_ctl_s ctl_o,
  output logic [4:0] mode_o,
  output logic [`OPM_VR_LVL_W-1:0] core_supply_voltage_o,
  output logic [NPERIPH-1:0] periph_clk_en_o,
  output logic boot_o,
  // l1 dma gate and pin release
  input wire logic dma_l1_cfg_i,
  output logic dma_l1_grant_o,
  output logic [NPINS-1:0] pin_oe_allow_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed
  {
    opm_pkg::opm_mode_e mode;
    logic pll_off;
    logic pll_byp;
    logic [`OPM_PLL_MUL_W-1:0] mul_pend;
    logic [`OPM_PLL_MUL_W-1:0] mul_act;
    logic [7:0] vr;
    logic [NPERIPH-1:0] pclk;
    logic [15:0] boot_cnt;
    logic boot;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] wake_prev;
  } opm_st_s;

  opm_st_s s_q;
  opm_st_s s_d;
  logic [2:0] wake_s;
  logic rtc_rise;
  logic ext_rise;
  logic rst_rise;
  logic wb_req;
  logic [1:0] mode_req;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // reset pin, rtc and external wakeups cross from outside the clock domain
  opm_sync #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({reset_pin_i, ext_wake_i, rtc_wake_i}),
    .sync_o(wake_s)
  );

  assign rtc_rise = wake_s[0] & ~s_q.wake_prev[0];
  assign ext_rise = wake_s[1] & ~s_q.wake_prev[1];
  assign rst_rise = wake_s[2] & ~s_q.wake_prev[2];
  assign wb_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign mode_req = wb_dat_i[`OPM_REQ_W-1:0];

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] pll_word;
    logic [31:0] nw;
    pll_word = '0;
    nw = '0;
    s_d = s_q;
    s_d.ack = wb_req;
    s_d.wake_prev = wake_s;
    pll_word[`OPM_PLL_OFF_BIT] = s_q.pll_off;
    pll_word[`OPM_PLL_BYP_BIT] = s_q.pll_byp;
    pll_word[`OPM_PLL_MUL_LSB +: `OPM_PLL_MUL_W] = s_q.mul_pend;
    if (s_q.boot_cnt != 16'h0000)
      s_d.boot_cnt = s_q.boot_cnt - 16'h0001;
    else
      s_d.boot = 1'b0;
    // register writes are only meaningful while the core is clocked
    if (wb_req && wb_we_i && (s_q.mode == opm_pkg::OPM_FULL || s_q.mode == opm_pkg::OPM_ACTIVE))
    begin
      unique case (wb_adr_i)
        `OPM_ADDR_PLL:
        begin
          nw = wmask(pll_word, wb_dat_i, wb_sel_i);
          s_d.pll_off = nw[`OPM_PLL_OFF_BIT];
          s_d.pll_byp = nw[`OPM_PLL_BYP_BIT];
          s_d.mul_pend = nw[`OPM_PLL_MUL_LSB +: `OPM_PLL_MUL_W];
          if (s_q.mode == opm_pkg::OPM_FULL && !nw[`OPM_PLL_BYP_BIT])
            s_d.mul_act = nw[`OPM_PLL_MUL_LSB +: `OPM_PLL_MUL_W];
          if (s_q.mode == opm_pkg::OPM_FULL && nw[`OPM_PLL_BYP_BIT])
            s_d.mode = opm_pkg::OPM_ACTIVE;
          if (s_q.mode == opm_pkg::OPM_ACTIVE && !nw[`OPM_PLL_BYP_BIT] && !nw[`OPM_PLL_OFF_BIT])
          begin
            s_d.mode = opm_pkg::OPM_FULL;
            s_d.mul_act = nw[`OPM_PLL_MUL_LSB +: `OPM_PLL_MUL_W];
          end
        end
        `OPM_ADDR_VR:
        begin
          nw = wmask({24'h000000, s_q.vr}, wb_dat_i, wb_sel_i);
          s_d.vr = nw[7:0];
          if (nw[`OPM_VR_REGULATOR_FREQUENCY_FIELD_LSB +: `OPM_VR_REGULATOR_FREQUENCY_FIELD_W] == `OPM_REGULATOR_FREQUENCY_FIELD_OFF)
            s_d.mode = opm_pkg::OPM_HIB;
        end
        `OPM_ADDR_MODE:
        begin
          if (wb_sel_i[0] && mode_req == `OPM_REQ_SLEEP && !s_q.pll_off)
            s_d.mode = opm_pkg::OPM_SLEEP;
          if (wb_sel_i[0] && mode_req == `OPM_REQ_DEEP)
            s_d.mode = opm_pkg::OPM_DEEP;
        end
        `OPM_ADDR_PCLK:
          s_d.pclk = NPERIPH'(wmask(32'(s_q.pclk), wb_dat_i, wb_sel_i));
        default:
        begin
        end
      endcase
    end
    // wakeups, evaluated on synchronised edges
    unique case (s_q.mode)
      opm_pkg::OPM_SLEEP:
      begin
        if (rst_rise)
          s_d.mode = opm_pkg::OPM_FULL;
        else if (rtc_rise || ext_rise)
          s_d.mode = s_q.pll_byp ? opm_pkg::OPM_ACTIVE : opm_pkg::OPM_FULL;
      end
      opm_pkg::OPM_DEEP:
      begin
        if (rst_rise)
          s_d.mode = opm_pkg::OPM_FULL;
        else if (rtc_rise)
          s_d.mode = opm_pkg::OPM_ACTIVE;
      end
      opm_pkg::OPM_HIB:
      begin
        if (rst_rise || rtc_rise)
        begin
          s_d.mode = rst_rise ? opm_pkg::OPM_FULL : opm_pkg::OPM_ACTIVE;
          s_d.vr = `OPM_VR_RST;
          s_d.pll_off = 1'b0;
          s_d.pll_byp = !rst_rise;
          s_d.boot = 1'b1;
          s_d.boot_cnt = BOOT_CYC;
        end
      end
      default:
      begin
        if (rst_rise)
        begin
          s_d.mode = opm_pkg::OPM_FULL;
          s_d.pll_byp = 1'b0;
          s_d.pll_off = 1'b0;
        end
      end
    endcase
    // read data
    unique case (wb_adr_i)
      `OPM_ADDR_PLL: s_d.rdat = pll_word;
      `OPM_ADDR_VR: s_d.rdat = {24'h000000, s_q.vr};
      `OPM_ADDR_MODE: s_d.rdat = {27'h0000000, s_q.mode};
      `OPM_ADDR_PCLK: s_d.rdat = 32'(s_q.pclk);
      `OPM_ADDR_STAT: s_d.rdat = {26'h0000000, s_q.boot, s_q.mode};
      default: s_d.rdat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.mode <= opm_pkg::OPM_FULL;
      s_q.mul_pend <= `OPM_MUL_RST;
      s_q.mul_act <= `OPM_MUL_RST;
      s_q.vr <= `OPM_VR_RST;
      s_q.pclk <= '1;
    end
    else
      s_q <= s_d;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  logic is_full;
  logic is_act;
  logic is_slp;
  assign is_full = s_q.mode == opm_pkg::OPM_FULL;
  assign is_act = s_q.mode == opm_pkg::OPM_ACTIVE;
  assign is_slp = s_q.mode == opm_pkg::OPM_SLEEP;

  assign ctl_o.pll_en = is_full | is_slp | (is_act & ~s_q.pll_off);
  // bypass passes the reference input clock straight to both clocks
  assign ctl_o.pll_bypass = is_act;
  assign ctl_o.core_clk_en = is_full | is_act;
  assign ctl_o.sys_clk_en = is_full | is_act | is_slp;
  assign ctl_o.core_pwr_on = s_q.mode != opm_pkg::OPM_HIB;
  assign ctl_o.mult = s_q.mul_act;
  assign mode_o = s_q.mode;
  assign core_supply_voltage_o = ctl_o.core_pwr_on ? s_q.vr[`OPM_VR_LVL_LSB +: `OPM_VR_LVL_W]
                                                  : '0;
  assign periph_clk_en_o = ctl_o.sys_clk_en ? s_q.pclk : '0;
  assign boot_o = s_q.boot;
  assign dma_l1_grant_o = dma_l1_cfg_i & (is_full | is_act);
  assign pin_oe_allow_o = ctl_o.core_pwr_on ? '1 : '0;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  mode_onehot_a: assert property (@(posedge clk_i) disable iff (rst_i) $onehot(s_q.mode))
    else $error("mode not one-hot");
  full_clocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_full |-> ctl_o.pll_en && !ctl_o.pll_bypass && ctl_o.core_clk_en && ctl_o.sys_clk_en)
    else $error("full-on settings wrong");
  reset_full_a: assert property (@(posedge clk_i) $fell(rst_i) |-> is_full)
    else $error("not full-on after reset");
  act_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_act |-> ctl_o.pll_bypass && ctl_o.core_clk_en)
    else $error("active settings wrong");
  sleep_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_slp && rtc_rise && !rst_rise |=> s_q.mode == ($past(s_q.pll_byp) ? opm_pkg::OPM_ACTIVE
                                                     : opm_pkg::OPM_FULL))
    else $error("sleep wakeup target wrong");
  sleep_dma_a: assert property (@(posedge clk_i) disable iff (rst_i)
    is_slp |-> !dma_l1_grant_o && !ctl_o.core_clk_en)
    else $error("dma granted in sleep");
  hib_power_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.mode == opm_pkg::OPM_HIB |-> !ctl_o.core_pwr_on && pin_oe_allow_o == '0
    && core_supply_voltage_o == '0)
    else $error("hibernate power not removed");
  deep_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.mode == opm_pkg::OPM_DEEP && rst_rise |=> is_full)
    else $error("deep sleep reset exit wrong");
  hib_boot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.mode == opm_pkg::OPM_HIB && rtc_rise && !rst_rise |=> boot_o && is_act)
    else $error("no boot after hibernate wake");

endmodule

/* core/opm_sync.sv */
// two flip-flop synchroniser for asynchronous wakeup and reset requests
`timescale 1ns/1ps
`include "opm_consts.svh"

module opm_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } opm_sync_s;

  opm_sync_s s_q;
  opm_sync_s s_d;

  // first stage feeds only the second stage
  always_comb
  begin
    s_d = s_q;
    s_d.meta = async_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sync_o = s_q.stable;

endmodule

/* inc/opm_consts.svh */
// register offsets, field positions, reset values and pin counts of the power mode controller
// ----------------------------------------------------------------------------
// How it works
// - exactly five modes: full-on, active, sleep, deep sleep, hibernate
// - full-on: pll on, unbypassed, clocks run, powered
// - power-up enters full-on mode
// - active: pll bypassed, enable optional, clocks run
// - bypassed clocks run at reference input frequency
// - multiplier written in active waits for full-on
// - active mode allows dma to configured l1
// - sleep stops core clock, pll and system run
// - sleep wakeup: bypass clear full-on, set active
// - sleep mode refuses system dma to l1
// - frequency field 00 enters hibernate, clocks off
// - hibernate drives core supply to zero volts
// - hibernate releases all external pins to high impedance
// - rtc wakeup or reset pin leaves hibernate
// - each peripheral clock individually gated
// - software may change core supply voltage level
// - deep sleep stops both clocks, pll off, powered
// - deep sleep exits: reset full-on, rtc active
// - regulator reactivation starts a boot sequence
// ----------------------------------------------------------------------------
`ifndef OPM_CONSTS_SVH
`define OPM_CONSTS_SVH

// ----------------------------------------------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OPM_ADDR_PLL 8'h00
`define OPM_ADDR_VR 8'h04
`define OPM_ADDR_MODE 8'h08
`define OPM_ADDR_PCLK 8'h0C
`define OPM_ADDR_STAT 8'h10
`define OPM_ADDR_W 8

// ----------------------------------------------------------------------------
// pll control setting fields
// ----------------------------------------------------------------------------
`define OPM_PLL_OFF_BIT 0
`define OPM_PLL_BYP_BIT 1
`define OPM_PLL_MUL_LSB 9
`define OPM_PLL_MUL_W 6
`define OPM_MUL_RST 6'h0A

// ----------------------------------------------------------------------------
// regulator control setting fields
// ----------------------------------------------------------------------------
`define OPM_VR_REGULATOR_FREQUENCY_FIELD_LSB 0
`define OPM_VR_REGULATOR_FREQUENCY_FIELD_W 2
`define OPM_VR_LVL_LSB 4
`define OPM_VR_LVL_W 4
`define OPM_VR_RST 8'hB3
`define OPM_REGULATOR_FREQUENCY_FIELD_OFF 2'h0

// ----------------------------------------------------------------------------
// mode request command codes written to the mode register
// ----------------------------------------------------------------------------
`define OPM_REQ_W 2
`define OPM_REQ_NONE 2'h0
`define OPM_REQ_SLEEP 2'h1
`define OPM_REQ_DEEP 2'h2
`define OPM_REQ_FULL 2'h3

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define OPM_NPERIPH 16
`define OPM_NPINS 32
`define OPM_BOOT_CYC 16'h0010

`endif

/* inc/opm_pkg.sv */
// types shared by the power mode controller files
package opm_pkg;

  // one-hot operating mode codes
  typedef enum logic [4:0]
  {
    OPM_FULL = 5'h01,
    OPM_ACTIVE = 5'h02,
    OPM_SLEEP = 5'h04,
    OPM_DEEP = 5'h08,
    OPM_HIB = 5'h10
  } opm_mode_e;

  // clock, pll and power controls sent to the clock tree
  typedef struct packed
  {
    logic pll_en;
    logic pll_bypass;
    logic core_clk_en;
    logic sys_clk_en;
    logic core_pwr_on;
    logic [5:0] mult;
  } opm_ctl_s;

  // classic wishbone request
  typedef struct packed
  {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } opm_wb_req_s;

endpackage

/* sim/opm_partner.sv */
// far side model: wakeup sources and reset pin that raise asynchronous levels
`timescale 1ns/1ps

module opm_partner (
  // wakeup levels toward the controller
  output logic rtc_wake_o,
  output logic ext_wake_o,
  output logic reset_pin_o
);
  initial
  begin
    rtc_wake_o = 1'b0;
    ext_wake_o = 1'b0;
    reset_pin_o = 1'b0;
  end

  // ----------------------------------------------------------------------------
  // pulse generator
  // ----------------------------------------------------------------------------
  // edges land off the controller clock on purpose; 40 ns outlasts the synchroniser
  task automatic pulse(input int src);
    #1.3;
    case (src)
      0: rtc_wake_o = 1'b1;
      1: ext_wake_o = 1'b1;
      default: reset_pin_o = 1'b1;
    endcase
    #40;
    rtc_wake_o = 1'b0;
    ext_wake_o = 1'b0;
    reset_pin_o = 1'b0;
  endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the operating mode power controller
`timescale 1ns/1ps
`include "opm_consts.svh"

module testbench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dma_l1_cfg_i;
  logic [3:0] wb_sel_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, pin_oe_allow_o, rdv;
  logic rtc_wake_i, ext_wake_i, reset_pin_i, boot_o, dma_l1_grant_o;
  opm_pkg::opm_ctl_s ctl_o;
  logic [4:0] mode_o;
  logic [3:0] core_supply_voltage_o;
  logic [15:0] periph_clk_en_o, pclk_x;
  int failures, comparisons, n, k;

  opm_ctrl #(.BOOT_CYC(16'h0002)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rtc_wake_i(rtc_wake_i),
    .ext_wake_i(ext_wake_i), .reset_pin_i(reset_pin_i), .ctl_o(ctl_o), .mode_o(mode_o),
    .core_supply_voltage_o(core_supply_voltage_o), .periph_clk_en_o(periph_clk_en_o),
    .boot_o(boot_o), .dma_l1_cfg_i(dma_l1_cfg_i), .dma_l1_grant_o(dma_l1_grant_o),
    .pin_oe_allow_o(pin_oe_allow_o));

  opm_partner partner (.rtc_wake_o(rtc_wake_i), .ext_wake_o(ext_wake_i),
    .reset_pin_o(reset_pin_i));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // classic single cycle; request held until ack is sampled high at a rising edge,
  // read data taken at that same edge, released only after it
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel = 4'hF);
    int j;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    j = 0;
    do
    begin
      @(posedge clk_i);
      j++;
    end
    while (wb_ack_o !== 1'b1 && j < 20);
    check({31'h0, wb_ack_o}, 32'h1);
    if (wb_ack_o !== 1'b1)
      close_out();
    rdv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // pins and peripheral clocks follow from the mode, so they are checked with it
  task automatic chk_state(input logic [4:0] md, input logic [10:0] ce, input logic [10:0] cm,
                           input logic gr);
    repeat (3) @(negedge clk_i);
    check({27'h0, mode_o}, {27'h0, md});
    check({21'h0, ctl_o & cm}, {21'h0, ce});
    check({31'h0, dma_l1_grant_o}, {31'h0, gr});
    check(pin_oe_allow_o, (md == 5'h10) ? 32'h0 : 32'hFFFFFFFF);
    check({16'h0, periph_clk_en_o}, (md & 5'h18) != 5'h0 ? 32'h0 : {16'h0, pclk_x});
  endtask

  // wakeups cross a synchroniser, so the wait is polled with a bound
  task automatic wait_mode(input logic [4:0] md);
    int j;
    for (j = 0; j < 40 && mode_o !== md; j++) @(negedge clk_i);
    check({27'h0, mode_o}, {27'h0, md});
    if (mode_o !== md)
      close_out();
  endtask

  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    failures = 0;
    comparisons = 0;
    pclk_x = 16'hFFFF;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    dma_l1_cfg_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_state(5'h01, 11'h5CA, 11'h7FF, 1'b1);
    wb(1'b0, `OPM_ADDR_PLL, 32'h0);
    check(rdv & 32'h7E03, 32'h1400);
    wb(1'b0, `OPM_ADDR_VR, 32'h0);
    check(rdv & 32'hFF, 32'hB3);
    check({28'h0, core_supply_voltage_o}, 32'hB);
    // unmapped place: reads zero and swallows writes
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    wb(1'b0, 8'h14, 32'h0);
    check(rdv, 32'h0);
    @(posedge clk_i);
    dma_l1_cfg_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check({31'h0, dma_l1_grant_o}, 32'h0);
    @(posedge clk_i);
    dma_l1_cfg_i <= 1'b1;
    // active mode, then a multiplier change that must wait for full-on
    wb(1'b1, `OPM_ADDR_PLL, 32'h1402);
    chk_state(5'h02, 11'h7CA, 11'h7FF, 1'b1);
    wb(1'b1, `OPM_ADDR_PLL, 32'h0A03);
    chk_state(5'h02, 11'h3CA, 11'h7FF, 1'b1);
    wb(1'b1, `OPM_ADDR_MODE, 32'h1);
    chk_state(5'h02, 11'h3CA, 11'h7FF, 1'b1);
    wb(1'b1, `OPM_ADDR_PLL, 32'h0A02);
    wb(1'b1, `OPM_ADDR_MODE, 32'h1);
    chk_state(5'h04, 11'h4C0, 11'h5C0, 1'b0);
    partner.pulse(1);
    wait_mode(5'h02);
    wb(1'b1, `OPM_ADDR_PLL, 32'h0A00);
    chk_state(5'h01, 11'h5C5, 11'h7FF, 1'b1);
    wb(1'b1, `OPM_ADDR_MODE, 32'h1);
    chk_state(5'h04, 11'h4C0, 11'h5C0, 1'b0);
    partner.pulse(0);
    wait_mode(5'h01);
    wb(1'b1, `OPM_ADDR_PCLK, 32'h000000A5);
    pclk_x = 16'h00A5;
    chk_state(5'h01, 11'h5C5, 11'h7FF, 1'b1);
    // only byte lane 1 is enabled, so the low enables must survive
    wb(1'b1, `OPM_ADDR_PCLK, 32'h00003C5A, 4'h2);
    pclk_x = 16'h3CA5;
    // lane 0 off: the sleep request never reaches the mode field
    wb(1'b1, `OPM_ADDR_MODE, 32'h1, 4'hE);
    chk_state(5'h01, 11'h5C5, 11'h7FF, 1'b1);
    // deep sleep: external events do not end it
    wb(1'b1, `OPM_ADDR_MODE, 32'h2);
    chk_state(5'h08, 11'h040, 11'h5C0, 1'b0);
    partner.pulse(1);
    chk_state(5'h08, 11'h040, 11'h5C0, 1'b0);
    partner.pulse(0);
    wait_mode(5'h02);
    wb(1'b1, `OPM_ADDR_PLL, 32'h0A00);
    wb(1'b1, `OPM_ADDR_MODE, 32'h2);
    chk_state(5'h08, 11'h040, 11'h5C0, 1'b0);
    partner.pulse(2);
    wait_mode(5'h01);
    wb(1'b1, `OPM_ADDR_VR, 32'h53);
    wb(1'b0, `OPM_ADDR_VR, 32'h0);
    check(rdv & 32'hFF, 32'h53);
    check({28'h0, core_supply_voltage_o}, 32'h5);
    // nothing internal worth keeping here, so hibernate may be requested at once
    wb(1'b1, `OPM_ADDR_VR, 32'h50);
    chk_state(5'h10, 11'h000, 11'h5C0, 1'b0);
    check({28'h0, core_supply_voltage_o}, 32'h0);
    n = 0;
    fork
      partner.pulse(0);
      for (k = 0; k < 60; k++)
      begin
        @(negedge clk_i);
        if (boot_o === 1'b1)
          n++;
      end
    join
    check(n, 32'd3);
    wait_mode(5'h02);
    check({28'h0, core_supply_voltage_o}, 32'hB);
    wb(1'b1, `OPM_ADDR_VR, 32'h50);
    chk_state(5'h10, 11'h000, 11'h5C0, 1'b0);
    partner.pulse(2);
    wait_mode(5'h01);
    // let the boot pulse run out before the status is read
    repeat (6) @(posedge clk_i);
    wb(1'b0, `OPM_ADDR_STAT, 32'h0);
    check(rdv & 32'h3F, 32'h01);
    // reset in mid-run brings back every power-up value
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    pclk_x = 16'hFFFF;
    chk_state(5'h01, 11'h5CA, 11'h7FF, 1'b1);
    check({28'h0, core_supply_voltage_o}, 32'hB);
    close_out();
  end
endmodule
